/* File: cmd_pkg.sv */
package cmd_pkg;
	localparam int BG_W = 2;
	localparam int BA_W = 2;
	localparam int ADDR_W = 18;
	localparam int OP_W = 14;
	localparam int AP_BIT = 10;
	localparam int BC_BIT = 12;
	localparam int BURST_LEN8 = 4;
	localparam int BURST_CHOP4 = 2;
	localparam logic [2:0] CODE_MRS = 3'h0;
	localparam logic [2:0] CODE_REF = 3'h1;
	localparam logic [2:0] CODE_PRE = 3'h2;
	localparam logic [2:0] CODE_RFU = 3'h3;
	localparam logic [2:0] CODE_WR = 3'h4;
	localparam logic [2:0] CODE_RD = 3'h5;
	localparam logic [2:0] CODE_ZQ = 3'h6;
	localparam logic [2:0] CODE_NOP = 3'h7;
	typedef enum logic [4:0] {
		CMD_NONE = 5'h00, CMD_MRS = 5'h01, CMD_REF = 5'h02, CMD_SRE = 5'h03,
		CMD_SRX = 5'h04, CMD_PRE = 5'h05, CMD_PREA = 5'h06, CMD_ACT = 5'h07,
		CMD_WR = 5'h08, CMD_RD = 5'h09, CMD_NOP = 5'h0a, CMD_DES = 5'h0b,
		CMD_PDE = 5'h0c, CMD_PDX = 5'h0d, CMD_ZQCL = 5'h0e, CMD_ZQCS = 5'h0f,
		CMD_ILLEGAL = 5'h10
	} cmd_t;
	typedef enum logic [3:0] {
		ST_ACTIVE = 4'h1, ST_PDOWN = 4'h2, ST_SREF = 4'h4, ST_BURST = 4'h8
	} pstate_t;
endpackage : cmd_pkg

/* File: cmd_if.sv */
interface cmd_if;
	logic cke;
	logic cs_n;
	logic act_n;
	logic [2:0] cmd_pins; // Row strobe, column strobe, write enable
	logic [1:0] bg;
	logic [1:0] ba;
	logic [17:0] addr; // Bits 16:14 unused here; they ride on cmd_pins
	logic odt;
	modport ctrl (output cke, cs_n, act_n, cmd_pins, bg, ba, addr, odt);
	modport dev (input cke, cs_n, act_n, cmd_pins, bg, ba, addr, odt);
endinterface : cmd_if

/* File: cmd_device.sv */
// Device end: samples the pins each edge and reports the decoded command
module cmd_device (
	input wire logic I_CORE_CLK,
	input wire logic I_RSTN,
	cmd_if.dev bus,
	input wire logic I_OTF_EN,
	output logic O_CMD_VALID,
	output cmd_pkg::cmd_t O_CMD,
	output logic [3:0] O_BANK,
	output logic [2:0] O_MR_SEL,
	output logic [13:0] O_OPCODE,
	output logic [17:0] O_ROW,
	output logic [9:0] O_COL,
	output logic O_AUTO_PRE,
	output logic O_CHOP4,
	output logic O_BURST_BUSY,
	output logic O_SELF_REF,
	output logic O_POWER_DOWN,
	output logic O_ODT_EN,
	output logic O_ILLEGAL
);
	// Pins come from another chip, so each passes two flops; reset holds idle pin levels
	logic [28:0] s1_q, s2_q;
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			s1_q <= {1'b1, 1'b1, 1'b1, 3'h7, 23'h0};
			s2_q <= {1'b1, 1'b1, 1'b1, 3'h7, 23'h0};
		end else begin
			s1_q <= {bus.cke, bus.cs_n, bus.act_n, bus.cmd_pins, bus.bg, bus.ba, bus.addr, bus.odt};
			s2_q <= s1_q;
		end
	end
	logic cke, cs_n, act_n, odt, cke_prev_q;
	logic [2:0] code;
	logic [1:0] bg, ba;
	logic [17:0] addr;
	assign {cke, cs_n, act_n, code, bg, ba, addr, odt} = s2_q;

	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) cke_prev_q <= 1'b1; // Idle level, so reset release shows no exit edge
		else cke_prev_q <= cke;
	end

	logic [2:0] burst_cnt_q;
	cmd_pkg::pstate_t st_q;
	cmd_pkg::cmd_t cmd_d;

	// Decode ignores don't-care pins; odt never enters it
	always_comb begin
		cmd_d = cmd_pkg::CMD_ILLEGAL;
		if (cke_prev_q && !cke) begin
			if (cs_n) cmd_d = cmd_pkg::CMD_PDE;
			else if (act_n && code == cmd_pkg::CODE_REF) cmd_d = cmd_pkg::CMD_SRE;
		end else if (!cke_prev_q && cke) begin
			if (cs_n) cmd_d = (st_q == cmd_pkg::ST_SREF) ? cmd_pkg::CMD_SRX : cmd_pkg::CMD_PDX;
			else if (act_n && code == cmd_pkg::CODE_NOP) cmd_d = cmd_pkg::CMD_SRX;
		end else if (!cke_prev_q) begin
			cmd_d = cmd_pkg::CMD_NONE; // Held low: maintain state
		end else if (cs_n) begin
			cmd_d = cmd_pkg::CMD_DES;
		end else if (!act_n) begin
			cmd_d = cmd_pkg::CMD_ACT;
		end else begin
			case (code)
				cmd_pkg::CODE_MRS: cmd_d = cmd_pkg::CMD_MRS;
				cmd_pkg::CODE_REF: cmd_d = cmd_pkg::CMD_REF;
				cmd_pkg::CODE_PRE: cmd_d = addr[cmd_pkg::AP_BIT] ? cmd_pkg::CMD_PREA : cmd_pkg::CMD_PRE;
				cmd_pkg::CODE_WR: cmd_d = cmd_pkg::CMD_WR;
				cmd_pkg::CODE_RD: cmd_d = cmd_pkg::CMD_RD;
				cmd_pkg::CODE_ZQ: cmd_d = addr[cmd_pkg::AP_BIT] ? cmd_pkg::CMD_ZQCL : cmd_pkg::CMD_ZQCS;
				cmd_pkg::CODE_NOP: cmd_d = cmd_pkg::CMD_NOP;
				default: cmd_d = cmd_pkg::CMD_ILLEGAL; // Reserved code
			endcase
		end
	end

	// Power state; refresh is not accepted in power-down
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) st_q <= cmd_pkg::ST_ACTIVE;
		else begin
			case (st_q)
				cmd_pkg::ST_ACTIVE: begin
					if (cmd_d == cmd_pkg::CMD_SRE) st_q <= cmd_pkg::ST_SREF;
					else if (cmd_d == cmd_pkg::CMD_PDE) st_q <= cmd_pkg::ST_PDOWN;
					else if (cmd_d == cmd_pkg::CMD_RD || cmd_d == cmd_pkg::CMD_WR) st_q <= cmd_pkg::ST_BURST;
				end
				cmd_pkg::ST_BURST: begin
					if (cmd_d == cmd_pkg::CMD_PDE) st_q <= cmd_pkg::ST_PDOWN;
					else if (burst_cnt_q == 3'h1 && cmd_d != cmd_pkg::CMD_RD && cmd_d != cmd_pkg::CMD_WR)
						st_q <= cmd_pkg::ST_ACTIVE;
				end
				cmd_pkg::ST_PDOWN: if (cmd_d == cmd_pkg::CMD_PDX) st_q <= cmd_pkg::ST_ACTIVE;
				cmd_pkg::ST_SREF: if (cmd_d == cmd_pkg::CMD_SRX) st_q <= cmd_pkg::ST_ACTIVE;
				default: st_q <= cmd_pkg::ST_ACTIVE;
			endcase
		end
	end

	// Burst counter runs on regardless of deselects or power-down
	logic chop_d;
	assign chop_d = I_OTF_EN && !addr[cmd_pkg::BC_BIT];
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) burst_cnt_q <= 3'h0;
		else if ((cmd_d == cmd_pkg::CMD_RD || cmd_d == cmd_pkg::CMD_WR) && st_q != cmd_pkg::ST_PDOWN)
			burst_cnt_q <= chop_d ? 3'(cmd_pkg::BURST_CHOP4) : 3'(cmd_pkg::BURST_LEN8);
		else if (burst_cnt_q != 3'h0) burst_cnt_q <= burst_cnt_q - 3'h1;
	end

	// Registered outputs; fields only update on accepted commands
	logic accept;
	assign accept = cmd_d != cmd_pkg::CMD_NONE && cmd_d != cmd_pkg::CMD_DES
		&& cmd_d != cmd_pkg::CMD_NOP && cmd_d != cmd_pkg::CMD_ILLEGAL;
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_CMD_VALID <= 1'b0;
			O_CMD <= cmd_pkg::CMD_NONE;
			O_BANK <= 4'h0;
			O_MR_SEL <= 3'h0;
			O_OPCODE <= 14'h0;
			O_ROW <= 18'h0;
			O_COL <= 10'h0;
			O_AUTO_PRE <= 1'b0;
			O_CHOP4 <= 1'b0;
			O_ILLEGAL <= 1'b0;
		end else begin
			O_CMD_VALID <= accept;
			O_CMD <= cmd_d;
			O_ILLEGAL <= cmd_d == cmd_pkg::CMD_ILLEGAL;
			if (accept) begin
				O_BANK <= {bg, ba};
				O_MR_SEL <= {bg[0], ba};
				O_OPCODE <= addr[13:0];
				O_ROW <= {addr[17], code, addr[13:0]};
				O_COL <= addr[9:0];
				O_AUTO_PRE <= addr[cmd_pkg::AP_BIT];
				O_CHOP4 <= chop_d;
			end
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_BURST_BUSY <= 1'b0;
			O_SELF_REF <= 1'b0;
			O_POWER_DOWN <= 1'b0;
			O_ODT_EN <= 1'b0;
		end else begin
			O_BURST_BUSY <= burst_cnt_q > 3'h1 || cmd_d == cmd_pkg::CMD_RD || cmd_d == cmd_pkg::CMD_WR;
			O_SELF_REF <= st_q == cmd_pkg::ST_SREF;
			O_POWER_DOWN <= st_q == cmd_pkg::ST_PDOWN;
			O_ODT_EN <= odt && st_q != cmd_pkg::ST_SREF;
		end
	end
endmodule : cmd_device

/* File: cmd_ctrl.sv */
// Controller end: turns one-cycle user requests into pin levels
module cmd_ctrl (
	input wire logic I_CORE_CLK,
	input wire logic I_RSTN,
	cmd_if.ctrl bus,
	input wire logic i_req,
	input wire cmd_pkg::cmd_t i_cmd,
	input wire logic [3:0] i_bank,
	input wire logic [17:0] i_addr,
	output logic o_busy
);
	logic cke_q, cs_n_q, act_n_q;
	logic [2:0] code_q;
	logic [1:0] bg_q, ba_q;
	logic [17:0] addr_q;
	logic sref_q;

	assign bus.cke = cke_q;
	assign bus.cs_n = cs_n_q;
	assign bus.act_n = act_n_q;
	assign bus.cmd_pins = code_q;
	assign bus.bg = bg_q;
	assign bus.ba = ba_q;
	assign bus.addr = addr_q;
	assign bus.odt = 1'b0;
	assign o_busy = 1'b0;

	// All pins but odt, which is tied low, change on our clock so they stand across the device edge
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			cke_q <= 1'b1;
			cs_n_q <= 1'b1;
			act_n_q <= 1'b1;
			code_q <= 3'h7;
			bg_q <= 2'h0;
			ba_q <= 2'h0;
			addr_q <= 18'h0;
			sref_q <= 1'b0;
		end else begin
			cs_n_q <= 1'b1; // Default deselect
			act_n_q <= 1'b1;
			code_q <= cmd_pkg::CODE_NOP;
			bg_q <= i_bank[3:2];
			ba_q <= i_bank[1:0];
			addr_q <= i_addr;
			if (i_req) begin
				case (i_cmd)
					cmd_pkg::CMD_MRS: begin
						cs_n_q <= 1'b0;
						code_q <= cmd_pkg::CODE_MRS;
						addr_q <= {1'b0, i_addr[16:0]};
					end
					cmd_pkg::CMD_REF: begin cs_n_q <= 1'b0; code_q <= cmd_pkg::CODE_REF; end
					cmd_pkg::CMD_SRE: begin
						cs_n_q <= 1'b0;
						code_q <= cmd_pkg::CODE_REF;
						cke_q <= 1'b0;
						sref_q <= 1'b1;
					end
					cmd_pkg::CMD_SRX, cmd_pkg::CMD_PDX: begin cke_q <= 1'b1; sref_q <= 1'b0; end
					cmd_pkg::CMD_PDE: cke_q <= 1'b0;
					cmd_pkg::CMD_PRE, cmd_pkg::CMD_PREA: begin
						cs_n_q <= 1'b0;
						code_q <= cmd_pkg::CODE_PRE;
						addr_q[cmd_pkg::AP_BIT] <= i_cmd == cmd_pkg::CMD_PREA;
					end
					cmd_pkg::CMD_ACT: begin
						cs_n_q <= 1'b0;
						act_n_q <= 1'b0;
						code_q <= i_addr[16:14];
					end
					cmd_pkg::CMD_WR: begin cs_n_q <= 1'b0; code_q <= cmd_pkg::CODE_WR; end
					cmd_pkg::CMD_RD: begin cs_n_q <= 1'b0; code_q <= cmd_pkg::CODE_RD; end
					cmd_pkg::CMD_ZQCL, cmd_pkg::CMD_ZQCS: begin
						cs_n_q <= 1'b0;
						code_q <= cmd_pkg::CODE_ZQ;
						addr_q[cmd_pkg::AP_BIT] <= i_cmd == cmd_pkg::CMD_ZQCL;
					end
					cmd_pkg::CMD_NOP: cs_n_q <= 1'b0;
					default: cs_n_q <= 1'b1; // Reserved code never driven
				endcase
			end
		end
	end
endmodule : cmd_ctrl

/* File: sdram_cmd_monitor.sv */
// Watches the pins that the controller end drives towards the device end
module sdram_cmd_monitor (
	input wire logic I_CORE_CLK,
	input wire logic I_RSTN,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic act_n,
	input wire logic [2:0] cmd_pins,
	input wire logic [1:0] bg,
	input wire logic [1:0] ba,
	input wire logic [17:0] addr,
	input wire logic odt
);
	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (!I_RSTN);
	// Selected with the activate pin high, so the three pins are a command
	logic sel;
	assign sel = !cs_n && act_n;
	property p_no_rsv;
		cke && sel |-> cmd_pins != 3'h3;
	endproperty
	a_no_rsv: assert property (p_no_rsv) else $error("reserved code on pins");
	property p_rst_idle;
		$rose(I_RSTN) |-> cke && cs_n;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("pins not idle after reset");
	property p_up_des;
		$rose(cke) |-> cs_n;
	endproperty
	a_up_des: assert property (p_up_des) else $error("bad exit code");
	// Falling clock enable is either power-down (deselect) or self refresh entry
	property p_down_des;
		$fell(cke) |-> cs_n || (act_n && cmd_pins == 3'h1);
	endproperty
	a_down_des: assert property (p_down_des) else $error("bad entry code");
	property p_mrs_a17;
		cke && sel && cmd_pins == 3'h0 |-> !addr[17];
	endproperty
	a_mrs_a17: assert property (p_mrs_a17) else $error("top address bit in mode set");
	property p_legal_cke;
		!cs_n && !(act_n && cmd_pins == 3'h1) |-> cke && $past(cke);
	endproperty
	a_legal_cke: assert property (p_legal_cke) else $error("command while asleep");
	property p_low_des;
		!cke && !$past(cke) |-> cs_n;
	endproperty
	a_low_des: assert property (p_low_des) else $error("selected with clock enable low");
	// No-operation is never allowed here; exit edges must deselect and a steady clock enable never carries it
	property p_no_nop;
		cke && $past(cke) && sel |-> cmd_pins != 3'h7;
	endproperty
	a_no_nop: assert property (p_no_nop) else $error("no-operation in steady state");
	// A burst must not be cut short by a power state change
	property p_burst_run;
		cke && sel && cmd_pins[2:1] == 2'b10 |=> cke [*4];
	endproperty
	a_burst_run: assert property (p_burst_run) else $error("clock enable dropped");
endmodule : sdram_cmd_monitor

/* File: sdram_command_decoder_bench.sv */
// Controller end and device end joined, driven from the request side
module sdram_command_decoder_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rstn, otf, req, seen, v, ap, c4, sr, pd, odte, busy, ill;
	cmd_pkg::cmd_t cmd, dcmd;
	logic [3:0] bank, dbank;
	logic [17:0] addr, row;
	logic [2:0] mrs;
	logic [13:0] op;
	logic [9:0] col;
	int errors, compares;
	cmd_pkg::cmd_t simple [5] = '{cmd_pkg::CMD_PRE, cmd_pkg::CMD_PREA, cmd_pkg::CMD_ZQCL,
		cmd_pkg::CMD_ZQCS, cmd_pkg::CMD_REF};
	cmd_if i_cmd_if ();
	cmd_ctrl i_cmd_ctrl (.I_CORE_CLK(clk), .I_RSTN(rstn), .bus(i_cmd_if), .i_req(req),
		.i_cmd(cmd), .i_bank(bank), .i_addr(addr), .o_busy());
	cmd_device i_cmd_device (.I_CORE_CLK(clk), .I_RSTN(rstn), .bus(i_cmd_if), .I_OTF_EN(otf),
		.O_CMD_VALID(v), .O_CMD(dcmd), .O_BANK(dbank), .O_MR_SEL(mrs), .O_OPCODE(op),
		.O_ROW(row), .O_COL(col), .O_AUTO_PRE(ap), .O_CHOP4(c4), .O_BURST_BUSY(busy),
		.O_SELF_REF(sr), .O_POWER_DOWN(pd), .O_ODT_EN(odte), .O_ILLEGAL(ill));
	sdram_cmd_monitor i_sdram_cmd_monitor (.I_CORE_CLK(clk), .I_RSTN(rstn),
		.cke(i_cmd_if.cke), .cs_n(i_cmd_if.cs_n), .act_n(i_cmd_if.act_n),
		.cmd_pins(i_cmd_if.cmd_pins), .bg(i_cmd_if.bg), .ba(i_cmd_if.ba),
		.addr(i_cmd_if.addr), .odt(i_cmd_if.odt));
	// 125 MHz core clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic chk_cmd(input cmd_pkg::cmd_t exp);
		compares++;
		if (seen !== 1'b1 || dcmd !== exp) begin
			errors++;
			$display("Error command expected %s seen %s", exp.name(), dcmd.name());
		end
	endtask : chk_cmd
	// Idle gap first so a burst from the last call has run out before the next request
	task automatic issue(input cmd_pkg::cmd_t c, input logic [3:0] b, input logic [17:0] a);
		repeat (4) @(posedge clk);
		#1;
		req = 1'b1;
		cmd = c;
		bank = b;
		addr = a;
		@(posedge clk);
		#1;
		req = 1'b0;
		seen = 1'b0;
		for (int i = 0; i < 8 && !seen; i++) begin
			@(posedge clk);
			#1;
			seen = (v === 1'b1);
		end
	endtask : issue
	task automatic complete_run;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	// Watchdog well beyond the expected run length
	initial begin
		#20000;
		errors++;
		complete_run();
	end
	initial begin
		rstn = 1'b0;
		otf = 1'b1;
		req = 1'b0;
		cmd = cmd_pkg::CMD_NONE;
		bank = 4'h0;
		addr = 18'h00000;
		repeat (6) @(posedge clk);
		#1;
		rstn = 1'b1;
		chk("reset cmd", 18'(cmd_pkg::CMD_NONE), 18'(dcmd));
		// A false exit after reset would stand at the third edge
		repeat (3) @(posedge clk);
		#1;
		chk("reset quiet", 18'h00000, 18'(v));
		issue(cmd_pkg::CMD_MRS, 4'h9, 18'h01234);
		chk_cmd(cmd_pkg::CMD_MRS);
		chk("mr select", 18'h00001, 18'(mrs));
		chk("opcode", 18'h01234, 18'(op));
		chk("illegal", 18'h00000, 18'(ill));
		issue(cmd_pkg::CMD_ACT, 4'h6, 18'h2abcd);
		chk_cmd(cmd_pkg::CMD_ACT);
		chk("row", 18'h2abcd, row);
		chk("bank", 18'h00006, 18'(dbank));
		issue(cmd_pkg::CMD_WR, 4'hc, 18'h00455);
		chk_cmd(cmd_pkg::CMD_WR);
		chk("col", 18'h00055, 18'(col));
		chk("auto pre wr", 18'h00001, 18'(ap));
		chk("chop wr", 18'h00001, 18'(c4));
		chk("burst busy", 18'h00001, 18'(busy));
		issue(cmd_pkg::CMD_RD, 4'h3, 18'h01123);
		chk_cmd(cmd_pkg::CMD_RD);
		chk("auto pre rd", 18'h00000, 18'(ap));
		chk("chop rd", 18'h00000, 18'(c4));
		// Full burst keeps busy for four edges, then drops
		repeat (3) @(posedge clk);
		#1;
		chk("burst len8", 18'h00001, 18'(busy));
		@(posedge clk);
		#1;
		chk("burst end", 18'h00000, 18'(busy));
		otf = 1'b0;
		issue(cmd_pkg::CMD_RD, 4'h3, 18'h00400);
		chk("chop fixed", 18'h00000, 18'(c4));
		foreach (simple[i]) begin
			issue(simple[i], 4'h5, 18'h00000);
			chk_cmd(simple[i]);
		end
		// Banks idle and no burst running before self refresh entry
		issue(cmd_pkg::CMD_SRE, 4'h0, 18'h00000);
		chk_cmd(cmd_pkg::CMD_SRE);
		@(posedge clk);
		#1;
		chk("self ref", 18'h00001, 18'(sr));
		chk("odt in sref", 18'h00000, 18'(odte));
		issue(cmd_pkg::CMD_SRX, 4'h0, 18'h00000);
		chk_cmd(cmd_pkg::CMD_SRX);
		@(posedge clk);
		#1;
		chk("sref left", 18'h00000, 18'(sr));
		issue(cmd_pkg::CMD_PDE, 4'h0, 18'h00000);
		chk_cmd(cmd_pkg::CMD_PDE);
		@(posedge clk);
		#1;
		chk("power down", 18'h00001, 18'(pd));
		issue(cmd_pkg::CMD_PDX, 4'h0, 18'h00000);
		chk_cmd(cmd_pkg::CMD_PDX);
		@(posedge clk);
		#1;
		chk("pd left", 18'h00000, 18'(pd));
		issue(cmd_pkg::CMD_DES, 4'h0, 18'h00000);
		chk("des valid", 18'h00000, 18'(seen));
		chk("illegal end", 18'h00000, 18'(ill));
		complete_run();
	end
endmodule : sdram_command_decoder_bench
